// [shared/afe_ctrl_defs.svh]
// register map, profile layout and link constants for the profile store controller
// Function
// - four-bit phase code, 22.5 degree steps
// - host uses even codes in divide-by-four mode
// - test waveform replaces converter word per channel
// - host enables decimation above 65 MSPS
// - 14-bit samples, saturation after offset correction
// - thirty-two profiles chosen by 5-bit index
// - 64-bit profile: reserved, bypass, start, reserved, stop
// - profiles at 0xF00-0xFFF, eight bytes each
// - host reads profiles only by streaming
// - MSB-first streaming starts at highest byte address
// - index write loads profile into current buffer
// - buffer load takes four serial clocks
// - MSB-first host clocks one extra byte
// - storage writes leave buffer; every index write reloads
// - profile bypass flag one skips highpass filter
// - power-start counts converter clocks after trigger
// - power-stop counts clocks; all-ones runs continuously
// - subtract per-channel offsets, channel-selected writes
// - offset bypass control skips correction
// - global bypass overrides profile bypass flag
// - trigger rise, index write with trigger bit clear, stop expiry idle block
`ifndef AFE_CTRL_DEFS_SVH
`define AFE_CTRL_DEFS_SVH
`define SAMPLE_W 14
`define REG_PHASE 13'h02D
`define REG_PIDX 13'h10C
`define REG_OFS_BYP 13'h10F
`define REG_OFS_A 13'h110
`define REG_OFS_B 13'h111
`define REG_GHPF 13'h113
`define REG_TWAVE 13'h11A
`define REG_CH_SEL 13'h0F0
`define REG_DEC_CTRL 13'h0F1
`define PROF_BASE 13'hF00
`define PIDX_W 5
`define SW_TRIG_BIT 5
`define GHPF_BIT 5
`define DEC_EN_BIT 0
`define OFS_BYP_MSB 2
`define OFS_HI_MSB 5
`define PHASE_MSB 3
`define PF_SKIP 31
`define PF_START 16
`define PF_STOP 0
`define PF_W 15
`define PSTOP_CONT 15'h7FFF
`define LOAD_SCLKS 3'h4
`define INSTR_LAST 4'hF
`define BYTE_LAST 3'h7
`define RD_BIT 15
`define W_MSB 14
`define W_LSB 13
`define W_STREAM 2'h3
`define WB_CMD 4'h0
`define WB_DLO 4'h4
`define WB_DHI 4'h8
`define WB_STAT 4'hC
`define CMD_RD 13
`define CMD_LEN 16
`endif

// [shared/afe_ctrl_pkg.sv]
// types shared by both ends of the configuration link
package afe_ctrl_pkg;
`include "afe_ctrl_defs.svh"
typedef logic signed [`SAMPLE_W-1:0] sample_t;
typedef enum logic [1:0] {H_IDLE = 2'h0, H_SHIFT = 2'h1, H_GAP = 2'h3} host_state_t;
typedef enum logic {R_IDLE = 1'h0, R_RUN = 1'h1} run_state_t;
endpackage: afe_ctrl_pkg

// [shared/spi_link_if.sv]
// three-wire serial configuration link between host and front end
`timescale 1ns/100ps
interface spi_link_if;
    logic sclk;
    logic csb;
    logic host_sdio_o;
    logic host_sdio_oe;
    logic dev_sdio_o;
    logic dev_sdio_oe;
    logic sdio;
    // idle line reads high, as with a pull-up
    assign sdio = dev_sdio_oe ? dev_sdio_o : (host_sdio_oe ? host_sdio_o : 1'b1);
    modport device (input sclk, input csb, input sdio, output dev_sdio_o, output dev_sdio_oe);
    modport host (output sclk, output csb, output host_sdio_o, output host_sdio_oe, input sdio);
endinterface: spi_link_if

// [verif/afe_link_sva.sv]
// link checker: timing relations on the serial configuration wires
`timescale 1ns/100ps
module afe_link_sva (
    input wire logic clk, // system clock
    input wire logic rst_b, // reset, active low
    input wire logic sclk, // serial clock
    input wire logic csb, // frame select, active low
    input wire logic host_sdio_o, // host data
    input wire logic host_sdio_oe, // host drive enable
    input wire logic dev_sdio_o, // device data
    input wire logic dev_sdio_oe // device drive enable
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    // half period of eight system clocks each way
    sequence s_high;
        sclk [*8] ##1 !sclk;
    endsequence
    sequence s_low;
        !sclk [*8];
    endsequence

    a_high_phase: assert property ($rose(sclk) |-> s_high) else $error("sclk high phase length wrong");
    a_low_phase: assert property ($fell(sclk) |-> s_low) else $error("sclk low phase too short");
    a_idle_clock: assert property (csb |-> !sclk) else $error("sclk moves outside a frame");
    a_frame_open: assert property ($fell(csb) |-> host_sdio_oe && !sclk) else $error("frame opens badly");
    a_frame_close: assert property ($rose(csb) |-> !host_sdio_oe) else $error("host still drives at end");
    a_no_fight: assert property (!(dev_sdio_oe && host_sdio_oe)) else $error("both ends drive data");
    a_dev_quiet: assert property (csb [*8] |-> !dev_sdio_oe) else $error("device drives while deselected");
    a_dev_turn: assert property ($rose(dev_sdio_oe) |-> !csb && !host_sdio_oe && !sclk)
        else $error("device turnaround out of place");
    // data may only move while the clock is low, so the sampling rise sees it settled
    a_host_hold: assert property (sclk && $past(sclk) && host_sdio_oe |-> $stable(host_sdio_o))
        else $error("host data moves while sclk high");
    a_dev_hold: assert property (sclk && $past(sclk) && dev_sdio_oe |-> $stable(dev_sdio_o))
        else $error("device data moves while sclk high");
endmodule: afe_link_sva

// [verif/test_profile_store_rf_decimator_ctrl.sv]
// self-checking bench: software host and front end joined over the serial link
`timescale 1ns/100ps
`include "afe_ctrl_defs.svh"
module test_profile_store_rf_decimator_ctrl;
    import afe_ctrl_pkg::*;
    logic clk, rst_b, cyc, stb, we, ack, trig, pup, run, ovld, hps;
    logic [3:0] adr, sel;
    logic [31:0] dw, dr;
    sample_t [7:0] adc, tst, odat;
    logic [7:0][3:0] ph;
    logic [7:0] sat;
    int mismatches, checked;
    spi_link_if link();
    afe_spi_host u_afe_spi_host (.clk(clk), .rst_b(rst_b), .link(link), .wb_cyc(cyc), .wb_stb(stb), .wb_we(we),
        .wb_adr(adr), .wb_sel(sel), .wb_dat_w(dw), .wb_dat_r(dr), .wb_ack(ack));
    afe_profile_ctrl u_afe_profile_ctrl (.clk(clk), .rst_b(rst_b), .link(link), .adc_data(adc), .test_data(tst),
        .transmit_trigger(trig), .phase_code(ph), .highpass_skip_flag(hps), .power_up(pup), .block_run(run),
        .out_data(odat), .out_valid(ovld), .sat(sat));
    afe_link_sva u_afe_link_sva (.clk(clk), .rst_b(rst_b), .sclk(link.sclk), .csb(link.csb),
        .host_sdio_o(link.host_sdio_o), .host_sdio_oe(link.host_sdio_oe), .dev_sdio_o(link.dev_sdio_o),
        .dev_sdio_oe(link.dev_sdio_oe));

    task automatic report_and_stop;
        $display("mismatches %0d checked %0d", mismatches, checked);
        if (mismatches == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask: report_and_stop

    task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
        checked++;
        if (got !== exp)
        begin
            mismatches++;
            $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask: chk

    task automatic guard(input int n, input int lim);
        if (n >= lim)
        begin
            mismatches++;
            $display("MISMATCH %0t wait ran out", $time);
            report_and_stop;
        end
    endtask: guard

    // classic single cycle; the slave's ack edge is the only sampling point
    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
        int n;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dw <= d;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 50);
        q = dr;
        cyc <= 1'b0;
        stb <= 1'b0;
        guard(n, 50);
    endtask: wb

    // one link frame: data staged, command issued, busy polled, result collected
    task automatic xfer(input logic rd, input logic [12:0] a, input logic [2:0] n1, input logic [63:0] d,
        output logic [63:0] q);
        logic [31:0] lo, hi;
        int n;
        wb(1'b1, 4'h4, d[31:0], lo);
        wb(1'b1, 4'h8, d[63:32], lo);
        wb(1'b1, 4'h0, {13'h0000, n1, 2'h0, rd, a}, lo);
        n = 0;
        do
        begin
            wb(1'b0, 4'hC, 32'h00000000, lo);
            n++;
        end while (lo[0] !== 1'b0 && n < 1000);
        guard(n, 1000);
        wb(1'b0, 4'h4, 32'h00000000, lo);
        wb(1'b0, 4'h8, 32'h00000000, hi);
        q = {hi, lo};
        // device applies a write a few clocks after the last rise
        repeat (8) @(posedge clk);
    endtask: xfer

    task automatic wr(input logic [12:0] a, input logic [7:0] d);
        logic [63:0] q;
        xfer(1'b0, a, 3'h0, {56'h0, d}, q);
    endtask: wr

    // trailing byte to an unmapped address supplies the load clocks
    task automatic ld(input logic [7:0] v);
        logic [63:0] q;
        xfer(1'b0, `REG_PIDX, 3'h1, {48'h0, v, 8'h00}, q);
    endtask: ld

    task automatic sample(input logic [13:0] e0, input logic [13:0] e7, input logic [7:0] es);
        int n;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end while (ovld !== 1'b1 && n < 100);
        guard(n, 100);
        chk({50'h0, odat[0]}, {50'h0, e0}, "channel 0 sample");
        chk({50'h0, odat[7]}, {50'h0, e7}, "channel 7 sample");
        chk({56'h0, sat}, {56'h0, es}, "saturation flags");
    endtask: sample

    task automatic count_valid(output int c);
        c = 0;
        repeat (64)
        begin
            @(posedge clk);
            if (ovld === 1'b1)
                c++;
        end
    endtask: count_valid

    function automatic logic [63:0] prof(input logic [4:0] p, input logic b, input logic [14:0] s,
        input logic [14:0] t);
        return {27'h5A5A5A5, p, b, s, 1'b1, t};
    endfunction: prof

    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    initial
    begin : main
        logic [63:0] q;
        logic [31:0] w;
        int cnt;
        rst_b = 1'b0;
        cyc = 1'b0;
        stb = 1'b0;
        we = 1'b0;
        adr = 4'h0;
        sel = 4'hF;
        dw = 32'h00000000;
        trig = 1'b1;
        adc = {8{14'h0064}};
        tst = {8{14'h2000}};
        mismatches = 0;
        checked = 0;
        repeat (8) @(posedge clk);
        rst_b <= 1'b1;
        wb(1'b0, 4'h2, 32'h00000000, w);
        chk({32'h0, w}, 64'h0, "unmapped bus read");
        for (int c = 0; c < 8; c++)
        begin
            wr(`REG_CH_SEL, 8'h01 << c);
            wr(`REG_PHASE, 8'(2 * c));
        end
        for (int c = 0; c < 8; c++)
            chk({60'h0, ph[c]}, 64'(2 * c), "phase code");
        xfer(1'b1, `REG_PHASE, 3'h0, 64'h0, q);
        chk(q, 64'h0E, "phase readback");
        xfer(1'b1, 13'h0555, 3'h0, 64'h0, q);
        chk(q, 64'h0, "unmapped link read");
        wr(`REG_CH_SEL, 8'hFF);
        xfer(1'b0, 13'hF07, 3'h7, prof(5'h00, 1'b0, 15'h0000, 15'h7FFF), q);
        xfer(1'b0, 13'hFFF, 3'h7, prof(5'h1F, 1'b1, 15'h0003, 15'h000A), q);
        xfer(1'b1, 13'hF07, 3'h7, 64'h0, q);
        chk(q, prof(5'h00, 1'b0, 15'h0000, 15'h7FFF), "first profile");
        xfer(1'b1, 13'hFFF, 3'h7, 64'h0, q);
        chk(q, prof(5'h1F, 1'b1, 15'h0003, 15'h000A), "last profile");
        ld(8'h1F);
        chk({63'h0, hps}, 64'h1, "bypass after load");
        xfer(1'b0, 13'hFFF, 3'h7, prof(5'h1F, 1'b0, 15'h0003, 15'h000A), q);
        chk({63'h0, hps}, 64'h1, "store write keeps buffer");
        ld(8'h1F);
        chk({63'h0, hps}, 64'h0, "same index reloads");
        wr(`REG_GHPF, 8'h20);
        chk({63'h0, hps}, 64'h1, "global bypass wins");
        wr(`REG_GHPF, 8'h00);
        // start 3, stop 10 ticks of two clocks each
        trig <= 1'b0;
        cnt = 0;
        repeat (200)
        begin
            @(posedge clk);
            if (pup === 1'b1)
                cnt++;
        end
        chk(64'(cnt), 64'((10 - 3) * 2), "power window length");
        chk({63'h0, run}, 64'h0, "stop expiry idles");
        trig <= 1'b1;
        repeat (8) @(posedge clk);
        ld(8'h00);
        wr(`REG_CH_SEL, 8'h80);
        wr(`REG_OFS_A, 8'h10);
        wr(`REG_OFS_B, 8'h00);
        wr(`REG_TWAVE, 8'h01);
        trig <= 1'b0;
        sample(14'h2000, 14'h0054, 8'h00);
        wr(`REG_CH_SEL, 8'h01);
        wr(`REG_OFS_A, 8'h10);
        wr(`REG_OFS_B, 8'h00);
        sample(14'h2000, 14'h0054, 8'h01);
        wr(`REG_OFS_BYP, 8'h07);
        sample(14'h2000, 14'h0054, 8'h00);
        count_valid(cnt);
        chk(64'(cnt), 64'd32, "full rate samples");
        wr(`REG_DEC_CTRL, 8'h01);
        count_valid(cnt);
        chk(64'(cnt), 64'd16, "decimated samples");
        chk({63'h0, run}, 64'h1, "continuous run");
        ld(8'h00);
        chk({63'h0, run}, 64'h0, "index write idles");
        ld(8'h20);
        chk({63'h0, run}, 64'h1, "software trigger runs");
        trig <= 1'b1;
        repeat (8) @(posedge clk);
        chk({63'h0, run}, 64'h0, "trigger rise idles");
        report_and_stop;
    end
endmodule: test_profile_store_rf_decimator_ctrl

// [verilog/afe_profile_ctrl.sv]
// front-end control: serial registers, profile store, offset path, power window
//
// The three-wire serial link interface to the registers was chosen for this implementation.
`timescale 1ns/100ps
`include "afe_ctrl_defs.svh"
module afe_profile_ctrl #(
    parameter int NCH = 8,
    parameter int ADC_DIV = 2
)
(
    input wire logic clk, // system clock
    input wire logic rst_b, // asynchronous reset, active low
    spi_link_if.device link, // serial configuration link
    input wire afe_ctrl_pkg::sample_t [NCH-1:0] adc_data, // converter words
    input wire afe_ctrl_pkg::sample_t [NCH-1:0] test_data, // test waveform words
    input wire logic transmit_trigger, // trigger pin, asynchronous
    output logic [NCH-1:0][`PHASE_MSB:0] phase_code, // demodulator phase per channel
    output logic highpass_skip_flag, // digital_highpass bypassed
    output logic power_up, // active channels powered
    output logic block_run, // digital block running
    output afe_ctrl_pkg::sample_t [NCH-1:0] out_data, // samples to framer
    output logic out_valid, // one-cycle sample strobe
    output logic [NCH-1:0] sat // saturation after offset correction
);
    import afe_ctrl_pkg::*;
    localparam int DIVW = $clog2(ADC_DIV + 1);
    localparam int MEMN = 256;
    typedef struct packed {
        logic sclk_m, sclk_s, sclk_p, csb_m, csb_s, sdi_m, sdi_s, trig_m, trig_s, trig_p;
        logic inst_done, done, rd, sdo, sdo_oe;
        logic [1:0] wcode, bcnt;
        logic [3:0] bitn;
        logic [15:0] sr;
        logic [12:0] addr;
        logic [7:0] tx, ph_r, oa_r, ob_r, byp_r, twave, ch_sel, dec_ctrl, ghpf, pidx_r;
        logic [NCH-1:0][`PHASE_MSB:0] phase;
        logic [NCH-1:0][`SAMPLE_W-1:0] ofs;
        logic [NCH-1:0] obyp;
        logic [2:0] load_cnt;
        logic [63:0] prof;
        logic hskip;
        run_state_t run;
        logic [15:0] cnt;
        logic pwr, dec_ph, ovalid;
        logic [DIVW-1:0] div;
        logic [NCH-1:0][`SAMPLE_W-1:0] odata;
        logic [NCH-1:0] sat;
    } state_t;
    state_t s_q, s_d;
    // profile store, byte organised as the serial port sees it
    logic [7:0] mem [0:MEMN-1];
    logic mem_we;
    logic [7:0] mem_wa;
    logic [7:0] mem_wd;
    logic rise, fall, tick, trig_fall, trig_rise;
    logic [15:0] sr_n;
    logic [63:0] fetched;
    logic signed [`SAMPLE_W:0] diff;
    logic [`SAMPLE_W:0] cl;
    sample_t x;

    function automatic logic in_prof(input logic [12:0] a);
        in_prof = (a >= `PROF_BASE);
    endfunction: in_prof

    // returns {saturated, clamped word}
    function automatic logic [`SAMPLE_W:0] clamp(input logic signed [`SAMPLE_W:0] v);
        if (v[`SAMPLE_W] != v[`SAMPLE_W-1])
            clamp = {1'b1, v[`SAMPLE_W], {(`SAMPLE_W-1){~v[`SAMPLE_W]}}};
        else
            clamp = {1'b0, v[`SAMPLE_W-1:0]};
    endfunction: clamp

    function automatic logic [7:0] rd_byte(input logic [12:0] a, input state_t st);
        case (a)
            `REG_PHASE: rd_byte = st.ph_r;
            `REG_PIDX: rd_byte = st.pidx_r;
            `REG_OFS_BYP: rd_byte = st.byp_r;
            `REG_OFS_A: rd_byte = st.oa_r;
            `REG_OFS_B: rd_byte = st.ob_r;
            `REG_GHPF: rd_byte = st.ghpf;
            `REG_TWAVE: rd_byte = st.twave;
            `REG_CH_SEL: rd_byte = st.ch_sel;
            `REG_DEC_CTRL: rd_byte = st.dec_ctrl;
            default: rd_byte = in_prof(a) ? mem[a[7:0]] : 8'h00;
        endcase
    endfunction: rd_byte

    // register writes; every control register holds one byte
    function automatic state_t wr_reg(input state_t st, input logic [12:0] a, input logic [7:0] d);
        wr_reg = st;
        case (a)
            `REG_PHASE:
            begin
                wr_reg.ph_r = d;
                for (int c = 0; c < NCH; c++)
                    if (st.ch_sel[c])
                        wr_reg.phase[c] = d[`PHASE_MSB:0];
            end
            `REG_OFS_A:
            begin
                wr_reg.oa_r = d;
                for (int c = 0; c < NCH; c++)
                    if (st.ch_sel[c])
                        wr_reg.ofs[c][7:0] = d;
            end
            `REG_OFS_B:
            begin
                wr_reg.ob_r = d;
                for (int c = 0; c < NCH; c++)
                    if (st.ch_sel[c])
                        wr_reg.ofs[c][`SAMPLE_W-1:8] = d[`OFS_HI_MSB:0];
            end
            `REG_OFS_BYP:
            begin
                wr_reg.byp_r = d;
                for (int c = 0; c < NCH; c++)
                    if (st.ch_sel[c])
                        wr_reg.obyp[c] = |d[`OFS_BYP_MSB:0];
            end
            `REG_PIDX:
            begin
                // trigger bit does not stick; the index always reloads
                wr_reg.pidx_r = {3'h0, d[`PIDX_W-1:0]};
                wr_reg.load_cnt = `LOAD_SCLKS;
                wr_reg.cnt = 16'h0;
                wr_reg.run = d[`SW_TRIG_BIT] ? R_RUN : R_IDLE;
            end
            `REG_GHPF: wr_reg.ghpf = d;
            `REG_TWAVE: wr_reg.twave = d;
            `REG_CH_SEL: wr_reg.ch_sel = d;
            `REG_DEC_CTRL: wr_reg.dec_ctrl = d;
            default: ;
        endcase
    endfunction: wr_reg

    always_comb
    begin
        s_d = s_q;
        mem_we = 1'b0;
        mem_wa = s_q.addr[7:0];
        mem_wd = 8'h00;
        diff = '0;
        cl = '0;
        x = '0;
        s_d.sclk_m = link.sclk;
        s_d.sclk_s = s_q.sclk_m;
        s_d.sclk_p = s_q.sclk_s;
        s_d.csb_m = link.csb;
        s_d.csb_s = s_q.csb_m;
        s_d.sdi_m = link.sdio;
        s_d.sdi_s = s_q.sdi_m;
        s_d.trig_m = transmit_trigger;
        s_d.trig_s = s_q.trig_m;
        s_d.trig_p = s_q.trig_s;
        rise = s_q.sclk_s && !s_q.sclk_p;
        fall = !s_q.sclk_s && s_q.sclk_p;
        trig_fall = !s_q.trig_s && s_q.trig_p;
        trig_rise = s_q.trig_s && !s_q.trig_p;
        tick = (s_q.div == DIVW'(ADC_DIV - 1));
        sr_n = {s_q.sr[14:0], s_q.sdi_s};
        for (int k = 0; k < 8; k++)
            fetched[k*8 +: 8] = mem[{s_q.pidx_r[`PIDX_W-1:0], 3'(k)}];

        // buffer load rides on serial clocks only, so a stalled link stalls it
        if (rise && s_q.load_cnt != 3'h0)
        begin
            s_d.load_cnt = s_q.load_cnt - 3'h1;
            if (s_q.load_cnt == 3'h1)
                s_d.prof = fetched;
        end

        // power window, counted in converter clocks
        s_d.div = tick ? '0 : s_q.div + DIVW'(1);
        if (trig_fall)
        begin
            s_d.run = R_RUN;
            s_d.cnt = 16'h0;
        end
        else if (trig_rise)
            s_d.run = R_IDLE;
        else if (s_q.run == R_RUN && tick)
        begin
            if (!(&s_q.cnt))
                s_d.cnt = s_q.cnt + 16'h1;
            // judged on the new count, so power drops on the stop tick itself
            if (s_q.prof[`PF_STOP +: `PF_W] != `PSTOP_CONT &&
                s_d.cnt >= {1'b0, s_q.prof[`PF_STOP +: `PF_W]})
                s_d.run = R_IDLE;
        end

        // serial slave; a frame abort clears instruction and done flags, bit count and drive enable
        if (s_q.csb_s)
        begin
            s_d.inst_done = 1'b0;
            s_d.done = 1'b0;
            s_d.bitn = 4'h0;
            s_d.sdo_oe = 1'b0;
        end
        else if (rise && !s_q.done)
        begin
            s_d.sr = sr_n;
            s_d.bitn = s_q.bitn + 4'h1;
            if (!s_q.inst_done && s_q.bitn == `INSTR_LAST)
            begin
                s_d.inst_done = 1'b1;
                s_d.bitn = 4'h0;
                s_d.bcnt = 2'h0;
                s_d.rd = sr_n[`RD_BIT];
                s_d.wcode = sr_n[`W_MSB:`W_LSB];
                s_d.addr = sr_n[12:0];
                s_d.tx = rd_byte(sr_n[12:0], s_q);
            end
            else if (s_q.inst_done && s_q.bitn[2:0] == `BYTE_LAST)
            begin
                s_d.bitn = 4'h0;
                s_d.bcnt = s_q.bcnt + 2'h1;
                // MSB-first streaming walks downward through the map
                s_d.addr = s_q.addr - 13'h1;
                s_d.tx = rd_byte(s_q.addr - 13'h1, s_q);
                if (s_q.wcode != `W_STREAM && s_q.bcnt == s_q.wcode)
                    s_d.done = 1'b1;
                if (!s_q.rd)
                begin
                    if (in_prof(s_q.addr))
                    begin
                        mem_we = 1'b1;
                        mem_wd = sr_n[7:0];
                    end
                    else
                        s_d = wr_reg(s_d, s_q.addr, sr_n[7:0]);
                end
            end
        end
        if (fall && !s_q.csb_s && s_q.inst_done && s_q.rd && !s_q.done)
        begin
            s_d.sdo = s_q.tx[7];
            s_d.tx = s_q.tx << 1;
            s_d.sdo_oe = 1'b1;
        end
        if (s_d.done)
            s_d.sdo_oe = 1'b0;

        s_d.hskip = s_q.ghpf[`GHPF_BIT] | s_q.prof[`PF_SKIP];
        s_d.pwr = (s_d.run == R_RUN) && (s_d.cnt >= {1'b0, s_q.prof[`PF_START +: `PF_W]});

        // datapath: one converter word per tick, halved when decimating
        s_d.ovalid = 1'b0;
        if (tick)
        begin
            s_d.dec_ph = ~s_q.dec_ph;
            if (s_q.pwr && (!s_q.dec_ctrl[`DEC_EN_BIT] || s_q.dec_ph))
            begin
                s_d.ovalid = 1'b1;
                for (int c = 0; c < NCH; c++)
                begin
                    x = s_q.twave[c] ? test_data[c] : adc_data[c];
                    diff = s_q.obyp[c] ? {x[`SAMPLE_W-1], x} :
                        {x[`SAMPLE_W-1], x} - {s_q.ofs[c][`SAMPLE_W-1], s_q.ofs[c]};
                    cl = clamp(diff);
                    s_d.odata[c] = cl[`SAMPLE_W-1:0];
                    s_d.sat[c] = cl[`SAMPLE_W];
                end
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            s_q <= '{csb_m: 1'b1, csb_s: 1'b1, run: R_IDLE, default: '0};
        else
            s_q <= s_d;
    end

    // no reset on the store: contents are undefined until written
    always_ff @(posedge clk)
    begin
        if (mem_we)
            mem[mem_wa] <= mem_wd;
    end

    assign link.dev_sdio_o = s_q.sdo;
    assign link.dev_sdio_oe = s_q.sdo_oe;
    assign phase_code = s_q.phase;
    assign highpass_skip_flag = s_q.hskip;
    assign power_up = s_q.pwr;
    assign block_run = s_q.run == R_RUN;
    assign out_data = s_q.odata;
    assign out_valid = s_q.ovalid;
    assign sat = s_q.sat;
endmodule: afe_profile_ctrl

// [verilog/afe_spi_host.sv]
// serial link master driven by software over classic Wishbone
`timescale 1ns/100ps
`include "afe_ctrl_defs.svh"
module afe_spi_host #(
    parameter int SCLK_HALF = 8
)
(
    input wire logic clk, // system clock
    input wire logic rst_b, // asynchronous reset, active low
    spi_link_if.host link, // serial link to the front end
    input wire logic wb_cyc, // bus cycle
    input wire logic wb_stb, // strobe
    input wire logic wb_we, // write enable
    input wire logic [3:0] wb_adr, // byte address
    input wire logic [3:0] wb_sel, // byte lanes
    input wire logic [31:0] wb_dat_w, // write data
    output logic [31:0] wb_dat_r, // read data
    output logic wb_ack // acknowledge
);
    import afe_ctrl_pkg::*;
    localparam int DW = $clog2(SCLK_HALF + 1);
    typedef struct packed {
        host_state_t st;
        logic [DW-1:0] div;
        logic sclk, csb, sdo, oe, rd, sdi_m, sdi_s, ack;
        logic [6:0] bitn, total;
        logic [2:0] len;
        logic [79:0] tx;
        logic [63:0] rx, dat;
        logic [31:0] cmd, dat_r;
    } hstate_t;
    hstate_t s_q, s_d;

    function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n, input logic [3:0] sel);
        for (int b = 0; b < 4; b++)
            merge[b*8 +: 8] = sel[b] ? n[b*8 +: 8] : o[b*8 +: 8];
    endfunction: merge

    always_comb
    begin
        logic half;
        logic [1:0] w;
        half = (s_q.div == DW'(SCLK_HALF - 1));
        w = 2'h0;
        s_d = s_q;
        s_d.sdi_m = link.sdio;
        s_d.sdi_s = s_q.sdi_m;
        s_d.ack = 1'b0;
        if (wb_cyc && wb_stb && !s_q.ack)
        begin
            s_d.ack = 1'b1;
            case (wb_adr)
                `WB_CMD: s_d.dat_r = s_q.cmd;
                `WB_DLO: s_d.dat_r = s_q.dat[31:0];
                `WB_DHI: s_d.dat_r = s_q.dat[63:32];
                `WB_STAT: s_d.dat_r = {31'h0, s_q.st != H_IDLE};
                default: s_d.dat_r = 32'h0;
            endcase
            // writes are ignored while a frame is on the link
            if (wb_we && s_q.st == H_IDLE)
            begin
                case (wb_adr)
                    `WB_DLO: s_d.dat[31:0] = merge(s_q.dat[31:0], wb_dat_w, wb_sel);
                    `WB_DHI: s_d.dat[63:32] = merge(s_q.dat[63:32], wb_dat_w, wb_sel);
                    `WB_CMD:
                    begin
                        s_d.cmd = merge(s_q.cmd, wb_dat_w, wb_sel);
                        s_d.len = s_d.cmd[`CMD_LEN +: 3];
                        s_d.rd = s_d.cmd[`CMD_RD];
                        w = (s_d.len >= 3'h3) ? `W_STREAM : s_d.len[1:0];
                        s_d.tx = {s_d.rd, w, s_d.cmd[12:0], s_q.dat << {3'(3'h7 - s_d.len), 3'h0}};
                        s_d.total = 7'h10 + {4'(s_d.len + 3'h1), 3'h0};
                        s_d.st = H_SHIFT;
                        s_d.bitn = 7'h0;
                        s_d.div = '0;
                        s_d.csb = 1'b0;
                        s_d.sclk = 1'b0;
                        s_d.sdo = s_d.tx[79];
                        s_d.oe = 1'b1;
                    end
                    default: ;
                endcase
            end
        end
        case (s_q.st)
            H_SHIFT:
            begin
                s_d.div = half ? '0 : s_q.div + DW'(1);
                if (half && !s_q.sclk)
                begin
                    s_d.sclk = 1'b1;
                    s_d.rx = {s_q.rx[62:0], s_q.sdi_s};
                end
                else if (half)
                begin
                    s_d.sclk = 1'b0;
                    s_d.bitn = s_q.bitn + 7'h1;
                    s_d.tx = s_q.tx << 1;
                    s_d.sdo = s_q.tx[78];
                    // release the line once the instruction is out on a read
                    s_d.oe = (s_d.bitn < 7'h10) || !s_q.rd;
                    if (s_d.bitn == s_q.total)
                    begin
                        s_d.csb = 1'b1;
                        s_d.oe = 1'b0;
                        s_d.st = H_GAP;
                        if (s_q.rd)
                            s_d.dat = s_q.rx & ({64{1'b1}} >> {3'(3'h7 - s_q.len), 3'h0});
                    end
                end
            end
            H_GAP:
            begin
                s_d.div = half ? '0 : s_q.div + DW'(1);
                if (half)
                    s_d.st = H_IDLE;
            end
            default: ;
        endcase
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            s_q <= '{st: H_IDLE, csb: 1'b1, default: '0};
        else
            s_q <= s_d;
    end

    assign link.sclk = s_q.sclk;
    assign link.csb = s_q.csb;
    assign link.host_sdio_o = s_q.sdo;
    assign link.host_sdio_oe = s_q.oe;
    assign wb_dat_r = s_q.dat_r;
    assign wb_ack = s_q.ack;
endmodule: afe_spi_host
